/* alarm_chan.sv */
// Purpose: trailing-window activity count and hysteresis of one alarm
// Assumes: at most one hit per cycle, window in ticks below 65536
// Notes: activity saturates at WIN_DEPTH; a hit on a full window drops
//        the oldest entry so the count stays pinned at the top
`timescale 1ns/1ps
module alarm_chan (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic [15:0] now,
    input wire logic hit,
    input wire logic [15:0] window,
    input wire logic [7:0] raise,
    input wire logic [7:0] clear,
    input wire logic [15:0] hold,
    output logic raised,
    output logic [4:0] activity
);
    typedef struct packed {
        ap::alarm_state_t st;
        logic [15:0][15:0] ts;
        logic [3:0] rp;
        logic [3:0] wp;
        logic [4:0] cnt;
        logic [15:0] hc;
    } chan_t;
    chan_t r;
    chan_t next_r;
    logic expire;
    logic full;
    logic over;
    logic [7:0] act;

    // ==========================================================
    // Window and hysteresis
    always_comb
    begin
        next_r = r;
        act = {3'h0, r.cnt};
        over = act > raise;
        expire = (r.cnt != 5'h0) && ((now - r.ts[r.rp]) >= window);
        full = r.cnt == 5'(ap::WIN_DEPTH);
        if (hit)
        begin
            next_r.ts[r.wp] = now;
            next_r.wp = r.wp + 4'h1;
        end
        if (expire || (hit && full))
            next_r.rp = r.rp + 4'h1;
        if (hit && !expire && !full)
            next_r.cnt = r.cnt + 5'h1;
        else if (!hit && expire)
            next_r.cnt = r.cnt - 5'h1;
        case (r.st)
            ap::IDLE:
                if (over)
                    next_r.st = ap::RAISED;
            ap::RAISED:
                if (!over)
                begin
                    if (hold == 16'h0)
                    begin
                        if (act < clear)
                            next_r.st = ap::IDLE;
                    end
                    else if (act <= clear)
                    begin
                        next_r.st = ap::HOLDING;
                        next_r.hc = hold;
                    end
                end
            ap::HOLDING:
                // Back to raised; the next drop reloads the full hold
                if (over)
                    next_r.st = ap::RAISED;
                else if (tick)
                begin
                    if (r.hc <= 16'h1)
                        next_r.st = ap::IDLE;
                    else
                        next_r.hc = r.hc - 16'h1;
                end
            default:
                next_r.st = ap::IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            r <= '0;
        else
            r <= next_r;
    end

    assign raised = r.st != ap::IDLE;
    assign activity = r.cnt;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_drop;
        r.st == ap::RAISED && !over && hold != 16'h0 && act <= clear;
    endsequence
    sequence s_expire;
        r.st == ap::HOLDING && !over && tick && r.hc == 16'h1;
    endsequence
    a_raise_on_excess: assert property (
        r.st == ap::IDLE && over |=> raised)
        else $error("alarm did not raise above raise threshold");
    a_stay_raised: assert property (
        raised && over |=> raised)
        else $error("alarm fell while activity above raise threshold");
    a_clear_no_hold: assert property (
        r.st == ap::RAISED && !over && hold == 16'h0 && act < clear
        |=> !raised)
        else $error("alarm without hold did not clear");
    a_hold_start: assert property (
        s_drop |=> r.st == ap::HOLDING && r.hc == $past(hold))
        else $error("hold countdown did not start with full value");
    a_hold_reload: assert property (
        r.st == ap::HOLDING && over |=> r.st == ap::RAISED)
        else $error("renewed activity did not cancel hold");
    a_hold_expire: assert property (
        s_expire |=> !raised)
        else $error("alarm survived hold expiry");
    a_window_push: assert property (
        hit && !expire && !full |=> activity == $past(activity) + 5'h1)
        else $error("matching hit not counted");
    a_reset_empty: assert property (disable iff (1'b0)
        rst |=> activity == 5'h0 && !raised)
        else $error("reset left alarm state behind");
endmodule

/* alarm_engine.sv */
// Purpose: eight pulse/pass alarm pairs with register access and interrupt
// Assumes: pulse measurements arrive synchronous to CORE_CLK
// Notes: time base is one tick per TICK_CYCLES clocks; alarms reset
//        while the engine is disabled
`timescale 1ns/1ps
module alarm_engine #(
    parameter int TICK_CYCLES = ap::TICK_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic [11:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    input wire logic PULSE_VALID,
    input wire logic [15:0] PULSE_FREQ,
    input wire logic [15:0] PULSE_DUR,
    input wire logic [1:0] PULSE_MIC,
    output logic [15:0] ALARM,
    output logic IRQ
);
    typedef struct packed {
        logic en;
        logic [15:0] irq_stat;
        logic [15:0] irq_mask;
        logic [15:0] prev;
        logic [31:0] trig_freq;
        logic [31:0] trig_dur;
        logic [31:0] trig_gap;
        logic [7:0][6:0][31:0] pcfg;
        logic [31:0] rdata;
        logic [31:0] pre;
        logic tick;
        logic [15:0] now;
        logic [15:0] alarm_out;
    } eng_t;
    eng_t r;
    eng_t next_r;

    logic [15:0] raised_v;
    logic [15:0][4:0] act_v;
    logic [7:0] pulse_hit;
    logic [7:0] pass_hit;
    logic [15:0] rise;
    logic [15:0] w1c;
    logic pulse_acc;
    logic pair_sel;
    logic [2:0] pair;
    logic [2:0] word;
    logic chan_rst;
    logic [31:0] rd_val;

    meas_if pulse_m ();
    meas_if pass_m ();

    // ==========================================================
    // Match expression
    // Enabled conditions combine by AND, or by OR when the op bit is
    // set; an empty OR never matches, an empty AND does for any enabled mic.
    function automatic logic match(
        input logic [31:0] f,
        input logic [31:0] d,
        input logic [31:0] c,
        input logic [15:0] fr,
        input logic [15:0] du,
        input logic [1:0] mic,
        input logic [7:0] cnt
    );
        logic [4:0] t;
        logic [4:0] e;
        logic any;
        logic all;
        t = {cnt >= c[ap::CRIT_CNT_LSB +: 8],
            du <= d[ap::MAX_LSB +: 16], du >= d[15:0],
            fr <= f[ap::MAX_LSB +: 16], fr >= f[15:0]};
        e = c[4:0];
        any = |(t & e);
        all = &(t | ~e);
        match = c[ap::CRIT_MIC_LSB + int'(mic)]
            && (c[ap::CRIT_OP_BIT] ? any : all);
    endfunction

    // ==========================================================
    // Trigger limits and pulse path
    assign pulse_acc = PULSE_VALID
        && PULSE_FREQ >= r.trig_freq[15:0]
        && PULSE_FREQ <= r.trig_freq[ap::MAX_LSB +: 16]
        && PULSE_DUR >= r.trig_dur[15:0]
        && PULSE_DUR <= r.trig_dur[ap::MAX_LSB +: 16];
    assign pulse_m.valid = pulse_acc;
    assign pulse_m.freq = PULSE_FREQ;
    assign pulse_m.dur = PULSE_DUR;
    assign pulse_m.mic = PULSE_MIC;
    assign pulse_m.count = 8'h01;
    assign chan_rst = RST || !r.en;

    pass_avg u_pass (
        .clk(CORE_CLK),
        .rst(chan_rst),
        .tick(r.tick),
        .gap(r.trig_gap[15:0]),
        .pulse(pulse_m),
        .pass(pass_m)
    );

    // ==========================================================
    // Alarm pairs
    for (genvar p = 0; p < ap::PAIRS; p++)
    begin : g_pair
        // One criteria set feeds both alarms of the pair
        assign pulse_hit[p] = pulse_acc && match(r.pcfg[p][ap::W_FREQ],
            r.pcfg[p][ap::W_DUR], r.pcfg[p][ap::W_CRIT],
            PULSE_FREQ, PULSE_DUR, PULSE_MIC, 8'h01);
        assign pass_hit[p] = pass_m.valid && match(r.pcfg[p][ap::W_FREQ],
            r.pcfg[p][ap::W_DUR], r.pcfg[p][ap::W_CRIT],
            pass_m.freq, pass_m.dur, pass_m.mic, pass_m.count);

        alarm_chan u_pulse (
            .clk(CORE_CLK),
            .rst(chan_rst),
            .tick(r.tick),
            .now(r.now),
            .hit(pulse_hit[p]),
            .window(r.pcfg[p][ap::W_PULSE_CFG][15:0]),
            .raise(r.pcfg[p][ap::W_PULSE_CFG][ap::CFG_RAISE_LSB +: 8]),
            .clear(r.pcfg[p][ap::W_PULSE_CFG][ap::CFG_CLEAR_LSB +: 8]),
            .hold(r.pcfg[p][ap::W_PULSE_HOLD][15:0]),
            .raised(raised_v[p]),
            .activity(act_v[p])
        );

        alarm_chan u_pass (
            .clk(CORE_CLK),
            .rst(chan_rst),
            .tick(r.tick),
            .now(r.now),
            .hit(pass_hit[p]),
            .window(r.pcfg[p][ap::W_PASS_CFG][15:0]),
            .raise(r.pcfg[p][ap::W_PASS_CFG][ap::CFG_RAISE_LSB +: 8]),
            .clear(r.pcfg[p][ap::W_PASS_CFG][ap::CFG_CLEAR_LSB +: 8]),
            .hold(r.pcfg[p][ap::W_PASS_HOLD][15:0]),
            .raised(raised_v[p + ap::PAIRS]),
            .activity(act_v[p + ap::PAIRS])
        );
    end

    // ==========================================================
    // Register decode
    assign pair_sel = REG_ADDR[11:8] == ap::PAIR_PAGE;
    assign pair = REG_ADDR[7:5];
    assign word = REG_ADDR[4:2];
    assign rise = raised_v & ~r.prev;
    assign w1c = (REG_WR && REG_ADDR == ap::A_IRQ_STAT)
        ? REG_WDATA[15:0] : 16'h0;

    always_comb
    begin
        rd_val = ap::R_ZERO;
        if (pair_sel)
        begin
            if (word == ap::W_ACT)
                // Pass alarms sit in the upper half of the vector
                rd_val = {19'h0, act_v[{1'b1, pair}], 3'h0,
                    act_v[{1'b0, pair}]};
            else
                rd_val = r.pcfg[pair][word];
        end
        else
            case (REG_ADDR)
                ap::A_CTRL: rd_val = {31'h0, r.en};
                ap::A_STATE: rd_val = {16'h0, raised_v};
                ap::A_IRQ_STAT: rd_val = {16'h0, r.irq_stat};
                ap::A_IRQ_MASK: rd_val = {16'h0, r.irq_mask};
                ap::A_TRIG_FREQ: rd_val = r.trig_freq;
                ap::A_TRIG_DUR: rd_val = r.trig_dur;
                ap::A_TRIG_GAP: rd_val = r.trig_gap;
                default: rd_val = ap::R_ZERO;
            endcase
    end

    // ==========================================================
    // Next state
    always_comb
    begin
        next_r = r;
        next_r.tick = 1'b0;
        if (r.pre >= 32'(TICK_CYCLES - 1))
        begin
            next_r.pre = 32'h0;
            next_r.tick = 1'b1;
            next_r.now = r.now + 16'h1;
        end
        else
            next_r.pre = r.pre + 32'h1;
        next_r.rdata = REG_RD ? rd_val : ap::R_ZERO;
        if (REG_WR)
        begin
            if (pair_sel && word != ap::W_ACT)
                next_r.pcfg[pair][word] = REG_WDATA;
            else
                case (REG_ADDR)
                    ap::A_CTRL: next_r.en = REG_WDATA[0];
                    ap::A_IRQ_MASK: next_r.irq_mask = REG_WDATA[15:0];
                    ap::A_TRIG_FREQ: next_r.trig_freq = REG_WDATA;
                    ap::A_TRIG_DUR: next_r.trig_dur = REG_WDATA;
                    ap::A_TRIG_GAP: next_r.trig_gap = REG_WDATA;
                    default: next_r.en = r.en;
                endcase
        end
        // A raise in the clearing cycle stays recorded
        next_r.irq_stat = (r.irq_stat & ~w1c) | rise;
        next_r.prev = raised_v;
        next_r.alarm_out = r.en ? raised_v : 16'h0;
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (RST)
        begin
            r <= '0;
            r.trig_freq <= ap::R_TRIG_LIM;
            r.trig_dur <= ap::R_TRIG_LIM;
            r.trig_gap <= ap::R_TRIG_GAP;
        end
        else
            r <= next_r;
    end

    assign REG_RDATA = r.rdata;
    assign ALARM = r.alarm_out;
    assign IRQ = |(r.irq_stat & r.irq_mask);

    // ==========================================================
    // Checks
    a_pin_gated: assert property (@(posedge CORE_CLK) disable iff (RST)
        !r.en |=> ALARM == 16'h0)
        else $error("alarm pins active while disabled");
    a_pin_follows: assert property (@(posedge CORE_CLK) disable iff (RST)
        r.en |=> ALARM == $past(raised_v))
        else $error("alarm pins do not follow alarm state");
    a_trig_filter: assert property (@(posedge CORE_CLK) disable iff (RST)
        PULSE_VALID && PULSE_FREQ < r.trig_freq[15:0]
        |-> pulse_hit == 8'h00)
        else $error("pulse below trigger limit reached an alarm");
    a_irq_sticky: assert property (@(posedge CORE_CLK) disable iff (RST)
        rise != 16'h0 |=> (r.irq_stat & $past(rise)) == $past(rise))
        else $error("raise event lost in interrupt status");
    a_state_read: assert property (@(posedge CORE_CLK) disable iff (RST)
        REG_RD && REG_ADDR == ap::A_STATE
        |=> REG_RDATA[15:0] == $past(raised_v))
        else $error("state read does not show alarm state");
    a_disable_clears: assert property (@(posedge CORE_CLK)
        disable iff (RST)
        !r.en |=> raised_v == 16'h0)
        else $error("alarm kept while engine disabled");
endmodule

/* alarm_engine_tb.sv */
// Purpose: self-checking bench of the alarm engine
// Assumes: a short tick so windows and holds fit a short run
// Notes: pair 1 takes random pulses, pair 0 the corner cases
`timescale 1ns/1ps
module alarm_engine_tb;
    localparam int TC = 8;
    localparam logic [11:0] P0 = 12'h100;
    localparam logic [11:0] P1 = 12'h120;
    logic CORE_CLK = 1'b0;
    logic RST = 1'b1;
    logic [11:0] REG_ADDR = 12'h000;
    logic [31:0] REG_WDATA = 32'h0;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [31:0] REG_RDATA;
    logic PULSE_VALID = 1'b0;
    logic [15:0] PULSE_FREQ = 16'h0;
    logic [15:0] PULSE_DUR = 16'h0;
    logic [1:0] PULSE_MIC = 2'h0;
    logic [15:0] ALARM;
    logic IRQ;
    logic [15:0] seen;
    logic [31:0] rd_val;
    integer seed = 32'hfd95;
    int n_errors = 0;
    int check_count = 0;
    int hits = 0;
    always #2.5 CORE_CLK = ~CORE_CLK;
    alarm_engine #(.TICK_CYCLES(TC)) alarm_engine_inst (
        .CORE_CLK(CORE_CLK), .RST(RST), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .PULSE_VALID(PULSE_VALID),
        .PULSE_FREQ(PULSE_FREQ), .PULSE_DUR(PULSE_DUR),
        .PULSE_MIC(PULSE_MIC), .ALARM(ALARM), .IRQ(IRQ));
    alarm_reader alarm_reader_inst (.clk(CORE_CLK), .alarm(ALARM),
        .latched(seen));
    // ==========================================
    // Bus, pulse and check tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a);
        @(posedge CORE_CLK);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        #1 rd_val = REG_RDATA;
    endtask
    task automatic pulse(input logic [15:0] f, input logic [1:0] m);
        @(posedge CORE_CLK);
        PULSE_VALID <= 1'b1;
        PULSE_FREQ <= f;
        PULSE_MIC <= m;
        PULSE_DUR <= 16'($random(seed));
        @(posedge CORE_CLK);
        PULSE_VALID <= 1'b0;
    endtask
    task automatic wait_seen(input int b, input logic v, input int lim);
        int i;
        for (i = 0; i < lim && seen[b] !== v; i++)
            @(posedge CORE_CLK);
        if (i == lim)
        begin
            n_errors++;
            finish_test();
        end
    endtask
    function automatic int exp_hit(input logic [15:0] f);
        return (f >= 16'h8000) ? 1 : 0;
    endfunction
    // ==========================================
    // Main sequence
    initial
    begin
        logic [15:0] f;
        repeat (16) @(posedge CORE_CLK);
        RST <= 1'b0;
        rd(ap::A_CTRL);
        chk(rd_val, ap::R_ZERO);
        rd(ap::A_TRIG_FREQ);
        chk(rd_val, ap::R_TRIG_LIM);
        rd(ap::A_TRIG_GAP);
        chk(rd_val, ap::R_TRIG_GAP);
        rd(12'hffc);
        chk(rd_val, ap::R_ZERO);
        wr(ap::A_CTRL, 32'h1);
        wr(ap::A_TRIG_GAP, 32'h2);
        wr(P1, 32'hffff_8000);
        wr(P1 + 12'h008, 32'h0000_0f01);
        wr(P1 + 12'h00c, 32'h00ff_ffff);
        repeat (8)
        begin
            f = 16'($random(seed));
            hits += exp_hit(f);
            pulse(f, 2'($random(seed)));
        end
        rd(P1 + 12'h01c);
        chk({27'h0, rd_val[4:0]}, 32'(hits));
        chk({16'h0, ALARM}, 32'h0);
        repeat (60) @(posedge CORE_CLK);
        // Pair 0: mic 1 only, frequency window, hold of 20 ticks
        wr(P0, 32'h3000_1000);
        wr(P0 + 12'h008, 32'h0000_0203);
        wr(P0 + 12'h00c, 32'h0101_000a);
        wr(P0 + 12'h010, 32'h0000_0014);
        wr(P0 + 12'h014, 32'h0000_0064);
        wr(ap::A_IRQ_MASK, 32'h1);
        wr(ap::A_TRIG_FREQ, 32'h1fff_0000);
        pulse(16'h2500, 2'h1);
        pulse(16'h1800, 2'h0);
        rd(P0 + 12'h01c);
        chk({27'h0, rd_val[4:0]}, 32'h0);
        wr(ap::A_TRIG_FREQ, ap::R_TRIG_LIM);
        repeat (40) @(posedge CORE_CLK);
        pulse(16'h1800, 2'h1);
        pulse(16'h1800, 2'h1);
        wait_seen(0, 1'b1, 20);
        rd(P0 + 12'h01c);
        chk({27'h0, rd_val[4:0]}, 32'h2);
        chk({27'h0, rd_val[12:8]}, 32'h0);
        chk({31'h0, IRQ}, 32'h1);
        wr(ap::A_IRQ_STAT, 32'h1);
        repeat (2) @(posedge CORE_CLK);
        chk({31'h0, IRQ}, 32'h0);
        wait_seen(8, 1'b1, 100);
        chk({31'h0, seen[8]}, 32'h1);
        // Window empties during this wait; at the check only the hold keeps it up
        repeat (80) @(posedge CORE_CLK);
        chk({31'h0, seen[0]}, 32'h1);
        wait_seen(0, 1'b0, 300);
        chk({31'h0, seen[0]}, 32'h0);
        wr(ap::A_CTRL, 32'h0);
        repeat (3) @(posedge CORE_CLK);
        chk({16'h0, ALARM}, 32'h0);
        finish_test();
    end
endmodule

/* alarm_reader.sv */
// Purpose: far-side controller that polls the alarm pins
// Assumes: one poll per clock, as a fast polling master would do
// Notes: keeps only the last poll, so a glitch shorter than a
//        clock is invisible, as it would be to the real controller
`timescale 1ns/1ps
module alarm_reader (
    input wire logic clk,
    input wire logic [15:0] alarm,
    output logic [15:0] latched
);
    // Every alarm state is taken on each poll
    always_ff @(posedge clk)
        latched <= alarm;
endmodule

/* ap.sv */
// Contract
// - Eight alarm pairs, each a pulse alarm and a pass alarm.
// - A pair shares one match expression; each alarm has own window and limits.
// - Match is Boolean over call parameters and microphone identity.
// - Pulse alarm tests every pulse, regardless of pass grouping.
// - Pulse activity counts matching pulses in the trailing pulse window.
// - Idle alarm raises when activity is strictly above raise threshold.
// - Raised alarm stays raised while activity stays above raise threshold.
// - Without hold, raised alarm clears when activity is strictly below clear threshold.
// - With hold, activity at or below clear threshold starts hold countdown.
// - Activity above raise threshold during countdown keeps alarm, reloads countdown.
// - Countdown expiry without renewed excess clears the alarm.
// - Pass parameters average a recording's pulses; pulse count is summed.
// - Pass activity counts matching passes in the trailing pass window.
// - Pass alarm uses the same hysteresis with its own settings.
// - Pass boundaries follow the capture trigger settings.
// - While enabled, every alarm state is visible to the controller.
// - Only pulses inside trigger frequency and duration limits are evaluated.
//
// Purpose: constants, register map and types of the alarm engine
// Assumes: 200 MHz core clock, time in ticks of one millisecond
// Notes: pair registers sit at PAIR_BASE + pair * 0x20 + word * 4
package ap;
    localparam int CLK_NS = 5;
    localparam int TICK_NS = 1000000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int PAIRS = 8;
    localparam int WIN_DEPTH = 16;
    localparam int DIV_STEPS = 24;
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_STATE = 12'h004;
    localparam logic [11:0] A_IRQ_STAT = 12'h008;
    localparam logic [11:0] A_IRQ_MASK = 12'h00c;
    localparam logic [11:0] A_TRIG_FREQ = 12'h010;
    localparam logic [11:0] A_TRIG_DUR = 12'h014;
    localparam logic [11:0] A_TRIG_GAP = 12'h018;
    localparam logic [3:0] PAIR_PAGE = 4'h1;
    localparam logic [2:0] W_FREQ = 3'h0;
    localparam logic [2:0] W_DUR = 3'h1;
    localparam logic [2:0] W_CRIT = 3'h2;
    localparam logic [2:0] W_PULSE_CFG = 3'h3;
    localparam logic [2:0] W_PULSE_HOLD = 3'h4;
    localparam logic [2:0] W_PASS_CFG = 3'h5;
    localparam logic [2:0] W_PASS_HOLD = 3'h6;
    localparam logic [2:0] W_ACT = 3'h7;
    localparam int MAX_LSB = 16;
    localparam int CRIT_OP_BIT = 5;
    localparam int CRIT_MIC_LSB = 8;
    localparam int CRIT_CNT_LSB = 16;
    localparam int CFG_RAISE_LSB = 16;
    localparam int CFG_CLEAR_LSB = 24;
    localparam int ACT_PASS_LSB = 8;
    localparam logic [31:0] R_ZERO = 32'h0000_0000;
    localparam logic [31:0] R_TRIG_LIM = 32'hffff_0000;
    localparam logic [31:0] R_TRIG_GAP = 32'h0000_0032;
    typedef enum logic [1:0] {IDLE = 2'b00, RAISED = 2'b01,
        HOLDING = 2'b11} alarm_state_t;
    typedef enum logic {COLLECT = 1'b0, DIVIDE = 1'b1} avg_state_t;
endpackage

/* meas_if.sv */
// Purpose: one pulse or pass measurement with its valid strobe
// Assumes: valid is a one-cycle pulse, fields stand beside it
// Notes: count is 1 for a single pulse
`timescale 1ns/1ps
interface meas_if;
    logic valid;
    logic [15:0] freq;
    logic [15:0] dur;
    logic [1:0] mic;
    logic [7:0] count;
    modport src (output valid, output freq, output dur, output mic,
        output count);
    modport dst (input valid, input freq, input dur, input mic,
        input count);
endinterface

/* pass_avg.sv */
// Purpose: groups accepted pulses into passes and averages them
// Assumes: pulses of one recording are closer than the trigger gap
// Notes: a pulse arriving during the closing cycle or the division is
//        not added to any pass; a pass closes early at 255 pulses
`timescale 1ns/1ps
module pass_avg (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic [15:0] gap,
    meas_if.dst pulse,
    meas_if.src pass
);
    typedef struct packed {
        ap::avg_state_t st;
        logic open;
        logic [23:0] sf;
        logic [23:0] sd;
        logic [8:0] rf;
        logic [8:0] rd;
        logic [7:0] n;
        logic [1:0] mic;
        logic [15:0] idle;
        logic [4:0] step;
        logic ov;
    } avg_t;
    avg_t r;
    avg_t next_r;
    logic [8:0] tf;
    logic [8:0] td;
    logic closing;

    // ==========================================================
    // Accumulate, then divide bit-serially to save a wide divider
    always_comb
    begin
        next_r = r;
        next_r.ov = 1'b0;
        tf = {r.rf[7:0], r.sf[23]};
        td = {r.rd[7:0], r.sd[23]};
        closing = r.open && ((r.idle >= gap) || r.n == 8'hff);
        case (r.st)
            ap::COLLECT:
                if (closing)
                begin
                    next_r.st = ap::DIVIDE;
                    next_r.open = 1'b0;
                    next_r.step = 5'h0;
                    next_r.rf = 9'h0;
                    next_r.rd = 9'h0;
                end
                else if (pulse.valid)
                begin
                    next_r.open = 1'b1;
                    next_r.idle = 16'h0;
                    next_r.sf = (r.open ? r.sf : 24'h0) + {8'h00, pulse.freq};
                    next_r.sd = (r.open ? r.sd : 24'h0) + {8'h00, pulse.dur};
                    next_r.n = (r.open ? r.n : 8'h0) + 8'h01;
                    if (!r.open)
                        next_r.mic = pulse.mic;
                end
                else if (r.open && tick)
                    next_r.idle = r.idle + 16'h1;
            ap::DIVIDE:
                if (r.step == 5'(ap::DIV_STEPS))
                begin
                    next_r.ov = 1'b1;
                    next_r.st = ap::COLLECT;
                end
                else
                begin
                    next_r.step = r.step + 5'h1;
                    next_r.rf = (tf >= {1'b0, r.n}) ? tf - {1'b0, r.n} : tf;
                    next_r.rd = (td >= {1'b0, r.n}) ? td - {1'b0, r.n} : td;
                    next_r.sf = {r.sf[22:0], tf >= {1'b0, r.n}};
                    next_r.sd = {r.sd[22:0], td >= {1'b0, r.n}};
                end
            default:
                next_r.st = ap::COLLECT;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            r <= '0;
        else
            r <= next_r;
    end

    assign pass.valid = r.ov;
    assign pass.freq = r.sf[15:0];
    assign pass.dur = r.sd[15:0];
    assign pass.mic = r.mic;
    assign pass.count = r.n;

    a_pass_close: assert property (@(posedge clk) disable iff (rst)
        r.st == ap::COLLECT && closing |-> ##26 pass.valid)
        else $error("closed pass not delivered after division");
endmodule
